// file: logic/pqa_pkg.sv
// package: opcodes, sources, widths and register offsets for the divide and scaling datapath
package pqa_pkg;
    localparam int WORD_W      = 16;
    localparam int LONG_W      = 32;
    localparam int ADDR_W      = 8;
    localparam int DIV_CYCLES  = 32;
    localparam int SCALE_W     = 6;
    localparam logic [ADDR_W-1:0] OFS_HI   = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_REMLO = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_REMHI = 8'h03;

    typedef enum logic [2:0] {
        OP_LONG_DIVIDE,
        OP_SHORT_DIVIDE,
        OP_SCALED_DIVIDE,
        OP_SCALED_MULTIPLY,
        OP_INT_TO_FIXED,
        OP_FIXED_TO_INT
    } pqa_op_t;

    typedef enum logic [1:0] {
        SRC_WORK,
        SRC_PARAM,
        SRC_IMM
    } pqa_src_t;
endpackage

// file: logic/pqa_div_if.sv
// interface: handshake between control and the iterative divider
`timescale 1ns/10ps
`default_nettype none
interface pqa_div_if;
    import pqa_pkg::*;
    logic              start;
    logic [LONG_W+SCALE_W-1:0] dividend;
    logic [LONG_W-1:0] divisor;
    logic              busy;
    logic              done;
    logic [LONG_W+SCALE_W-1:0] quotient;
    logic [LONG_W-1:0] remainder;
    modport ctrl (output start, dividend, divisor, input busy, done, quotient, remainder);
    modport unit (input start, dividend, divisor, output busy, done, quotient, remainder);
endinterface
`default_nettype wire

// file: logic/pqa_divider.sv
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module pqa_divider #(
    parameter int N = 38,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rstSyncN,
    // control side
    pqa_div_if.unit   dv
);
    import pqa_pkg::*;

    logic [N-1:0] quo_r;
    logic [D:0]   rem_r;
    logic [D-1:0] den_r;
    logic [6:0]   cnt_r;
    logic         busy_r;
    logic         done_r;
    logic [D:0]   trial;

    assign trial = {rem_r[D-1:0], quo_r[N-1]} - {1'b0, den_r};

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            quo_r  <= '0;
            rem_r  <= '0;
            den_r  <= '0;
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (dv.start && !busy_r) begin
                quo_r  <= dv.dividend;
                den_r  <= dv.divisor;
                rem_r  <= '0;
                cnt_r  <= 7'(N);
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (!trial[D]) begin
                    rem_r <= {1'b0, trial[D-1:0]};
                    quo_r <= {quo_r[N-2:0], 1'b1};
                end else begin
                    rem_r <= {rem_r[D-1:0], quo_r[N-1]};
                    quo_r <= {quo_r[N-2:0], 1'b0};
                end
                cnt_r <= cnt_r - 7'h01;
                if (cnt_r == 7'h01) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

    assign dv.busy      = busy_r;
    assign dv.done      = done_r;
    assign dv.quotient  = quo_r;
    assign dv.remainder = rem_r[D-1:0];
endmodule
`default_nettype wire

// file: logic/pqa_alu.sv
// divide and fixed-point scaling datapath for the logic-controller instruction set
`timescale 1ns/10ps
`default_nettype none
module pqa_alu (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    // instruction from sequencer
    input  wire logic                     issue,
    input  wire pqa_pkg::pqa_op_t         opcode,
    input  wire pqa_pkg::pqa_src_t        srcA,
    input  wire pqa_pkg::pqa_src_t        srcB,
    input  wire logic [pqa_pkg::ADDR_W-1:0] addrA,
    input  wire logic [pqa_pkg::ADDR_W-1:0] addrB,
    input  wire logic [pqa_pkg::LONG_W-1:0] immVal,
    input  wire logic [pqa_pkg::SCALE_W-1:0] scaleA,
    input  wire logic [pqa_pkg::SCALE_W-1:0] scaleB,
    input  wire logic [pqa_pkg::SCALE_W-1:0] scaleR,
    input  wire logic [pqa_pkg::ADDR_W-1:0] dstBase,
    // register storage read port (same-cycle data)
    output logic                          rdWork_r,
    output logic [pqa_pkg::ADDR_W-1:0]    rdAddr_r,
    input  wire logic [pqa_pkg::WORD_W-1:0] rdData,
    // working register write port
    output logic                          wrEn_r,
    output logic [pqa_pkg::ADDR_W-1:0]    wrAddr_r,
    output logic [pqa_pkg::WORD_W-1:0]    wrData_r,
    // status
    output logic                          busy_r,
    output logic                          done_r,
    output logic                          fault_r,
    input  wire logic                     faultClr
);
    import pqa_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_RDA, S_RDB, S_EXEC, S_SHORT_DIVIDE_OP, S_WRITE} pqa_state_t;

    logic         rstQ1_r, rstSyncN;
    pqa_state_t   state_r;
    pqa_op_t      op_r;
    pqa_src_t     sA_r, sB_r;
    logic [ADDR_W-1:0] aA_r, aB_r, dst_r;
    logic [LONG_W-1:0] imm_r, opA_r, opB_r;
    logic [SCALE_W-1:0] scA_r, scB_r, scR_r;
    logic [1:0]   rdIdx_r, wrIdx_r, wrLast_r;
    logic [4*WORD_W-1:0] res_r;
    logic         negQ_r, negR_r, faultSet;
    logic [LONG_W+SCALE_W-1:0] divQ;
    logic signed [2*LONG_W-1:0] prod;
    logic signed [SCALE_W:0] shMul;
    logic [LONG_W-1:0] magA, magB;
    pqa_div_if    dv ();

    // reset release through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstQ1_r  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstQ1_r  <= 1'b1;
            rstSyncN <= rstQ1_r;
        end
    end

    pqa_divider #(.N(LONG_W+SCALE_W), .D(LONG_W)) uDiv (
        .core_clk (core_clk),
        .rstSyncN (rstSyncN),
        .dv       (dv)
    );

    assign magA = opA_r[LONG_W-1] ? LONG_W'(-opA_r) : opA_r;
    assign magB = opB_r[LONG_W-1] ? LONG_W'(-opB_r) : opB_r;
    assign divQ = negQ_r ? (LONG_W+SCALE_W)'(-dv.quotient) : dv.quotient;
    // product rescaled by scaleR - (scaleA + scaleB)
    assign prod  = $signed(opA_r) * $signed(opB_r);
    assign shMul = (SCALE_W+1)'(scA_r) + (SCALE_W+1)'(scB_r) - (SCALE_W+1)'(scR_r);
    assign faultSet = (state_r == S_EXEC) && (op_r inside {OP_LONG_DIVIDE, OP_SHORT_DIVIDE, OP_SCALED_DIVIDE})
                      && (opB_r == '0);

    // capture instruction
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            op_r <= OP_LONG_DIVIDE;
            sA_r <= SRC_WORK;
            sB_r <= SRC_WORK;
            aA_r <= '0;
            aB_r <= '0;
            dst_r <= '0;
            imm_r <= '0;
            scA_r <= '0;
            scB_r <= '0;
            scR_r <= '0;
        end else if (issue && state_r == S_IDLE) begin
            op_r <= opcode;
            sA_r <= srcA;
            sB_r <= srcB;
            aA_r <= addrA;
            aB_r <= addrB;
            dst_r <= dstBase;
            imm_r <= immVal;
            scA_r <= scaleA;
            scB_r <= scaleB;
            scR_r <= scaleR;
        end
    end

    // sequencing, operand fetch and result computation
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_r  <= S_IDLE;
            rdIdx_r  <= '0;
            rdWork_r <= 1'b0;
            rdAddr_r <= '0;
            opA_r    <= '0;
            opB_r    <= '0;
            res_r    <= '0;
            wrLast_r <= '0;
            negQ_r   <= 1'b0;
            negR_r   <= 1'b0;
            dv.start <= 1'b0;
            dv.dividend <= '0;
            dv.divisor  <= '0;
        end else begin
            dv.start <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    rdIdx_r <= '0;
                    if (issue) begin
                        state_r  <= S_RDA;
                        rdWork_r <= (srcA == SRC_WORK);
                        rdAddr_r <= addrA;
                    end
                end
                S_RDA: begin
                    if (sA_r == SRC_IMM) begin
                        opA_r <= (op_r == OP_SHORT_DIVIDE) ? {{WORD_W{imm_r[WORD_W-1]}}, imm_r[WORD_W-1:0]} : imm_r;
                    end else if (rdIdx_r == 2'd0) begin
                        opA_r[WORD_W-1:0] <= rdData;
                    end else begin
                        opA_r[LONG_W-1:WORD_W] <= (op_r == OP_SHORT_DIVIDE) ? {WORD_W{rdData[WORD_W-1]}} : rdData;
                        opA_r[WORD_W-1:0] <= (op_r == OP_SHORT_DIVIDE) ? rdData : opA_r[WORD_W-1:0];
                    end
                    if (sA_r == SRC_IMM || rdIdx_r == 2'd1 || (op_r == OP_SHORT_DIVIDE && rdIdx_r == 2'd0)) begin
                        if (op_r == OP_SHORT_DIVIDE && sA_r != SRC_IMM) begin
                            opA_r <= {{WORD_W{rdData[WORD_W-1]}}, rdData};
                        end
                        rdIdx_r  <= '0;
                        rdWork_r <= (sB_r == SRC_WORK);
                        rdAddr_r <= aB_r;
                        state_r  <= (op_r inside {OP_INT_TO_FIXED, OP_FIXED_TO_INT}) ? S_EXEC : S_RDB;
                    end else begin
                        rdIdx_r  <= 2'd1;
                        rdAddr_r <= aA_r + OFS_HI;
                    end
                end
                S_RDB: begin
                    if (sB_r == SRC_IMM) begin
                        opB_r <= (op_r == OP_SHORT_DIVIDE) ? {{WORD_W{imm_r[WORD_W-1]}}, imm_r[WORD_W-1:0]} : imm_r;
                    end else if (op_r == OP_SHORT_DIVIDE) begin
                        opB_r <= {{WORD_W{rdData[WORD_W-1]}}, rdData};
                    end else if (rdIdx_r == 2'd0) begin
                        opB_r[WORD_W-1:0] <= rdData;
                    end else begin
                        opB_r[LONG_W-1:WORD_W] <= rdData;
                    end
                    if (sB_r == SRC_IMM || rdIdx_r == 2'd1 || op_r == OP_SHORT_DIVIDE) begin
                        state_r <= S_EXEC;
                    end else begin
                        rdIdx_r  <= 2'd1;
                        rdAddr_r <= aB_r + OFS_HI;
                    end
                end
                S_EXEC: begin
                    negQ_r <= opA_r[LONG_W-1] ^ opB_r[LONG_W-1];
                    negR_r <= opA_r[LONG_W-1];
                    case (op_r)
                        OP_LONG_DIVIDE, OP_SHORT_DIVIDE, OP_SCALED_DIVIDE: begin
                            if (faultSet) begin
                                state_r <= S_IDLE;
                            end else begin
                                dv.start    <= 1'b1;
                                dv.dividend <= (op_r == OP_SCALED_DIVIDE) ?
                                               ({{SCALE_W{1'b0}}, magA} << scR_r) : {{SCALE_W{1'b0}}, magA};
                                dv.divisor  <= magB;
                                state_r     <= S_SHORT_DIVIDE_OP;
                            end
                        end
                        OP_SCALED_MULTIPLY: begin
                            res_r    <= {32'h0, shMul[SCALE_W] ? 32'(prod <<< (-shMul)) : 32'(prod >>> shMul)};
                            wrLast_r <= 2'd1;
                            state_r  <= S_WRITE;
                        end
                        OP_INT_TO_FIXED: begin
                            res_r    <= {32'h0, opA_r << scR_r};
                            wrLast_r <= 2'd1;
                            state_r  <= S_WRITE;
                        end
                        OP_FIXED_TO_INT: begin
                            res_r    <= {32'h0, 32'($signed(opA_r) >>> scR_r)};
                            wrLast_r <= 2'd1;
                            state_r  <= S_WRITE;
                        end
                        default: state_r <= S_IDLE;
                    endcase
                end
                S_SHORT_DIVIDE_OP: begin
                    if (dv.done && !dv.busy) begin
                        state_r <= S_WRITE;
                        case (op_r)
                            OP_LONG_DIVIDE: begin
                                res_r    <= {negR_r ? LONG_W'(-dv.remainder) : dv.remainder, divQ[LONG_W-1:0]};
                                wrLast_r <= 2'd3;
                            end
                            OP_SHORT_DIVIDE: begin
                                res_r    <= {32'h0, negR_r ? WORD_W'(-dv.remainder) : dv.remainder[WORD_W-1:0],
                                             divQ[WORD_W-1:0]};
                                wrLast_r <= 2'd1;
                            end
                            default: begin
                                res_r    <= {32'h0, divQ[LONG_W-1:0]};
                                wrLast_r <= 2'd1;
                            end
                        endcase
                    end
                end
                S_WRITE: begin
                    res_r <= res_r >> WORD_W;
                    if (wrIdx_r == wrLast_r) begin
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // working register writes, base upward
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrEn_r   <= 1'b0;
            wrAddr_r <= '0;
            wrData_r <= '0;
            wrIdx_r  <= '0;
        end else begin
            wrEn_r <= (state_r == S_WRITE);
            if (state_r == S_WRITE) begin
                wrAddr_r <= dst_r + ADDR_W'(wrIdx_r);
                wrData_r <= res_r[WORD_W-1:0];
                wrIdx_r  <= wrIdx_r + 2'd1;
            end else begin
                wrIdx_r <= '0;
            end
        end
    end

    // status: busy, done and sticky fault
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            busy_r <= (state_r != S_IDLE) || issue;
            done_r <= (state_r == S_WRITE && wrIdx_r == wrLast_r) || faultSet;
            fault_r <= faultSet | (fault_r & ~faultClr);
        end
    end
endmodule
`default_nettype wire

// file: tb/pqa_regs_model.sv
// register storage model: working and parameter areas
`timescale 1ns/10ps
`default_nettype none
module pqa_regs_model (
    // clock
    input  wire logic        core_clk,
    // read port
    input  wire logic        rdWork,
    input  wire logic [7:0]  rdAddr,
    output logic [15:0]      rdData,
    // write port, working area only
    input  wire logic        wrEn,
    input  wire logic [7:0]  wrAddr,
    input  wire logic [15:0] wrData
);
    logic [15:0] workMem [256];
    logic [15:0] parmMem [256];
    // same-cycle read data
    assign rdData = rdWork ? workMem[rdAddr] : parmMem[rdAddr];
    always @(posedge core_clk) begin
        if (wrEn) begin
            workMem[wrAddr] <= wrData;
        end
    end
endmodule
`default_nettype wire

// file: tb/pqa_alu_monitor.sv
// checker for the divide and scaling datapath ports
`timescale 1ns/10ps
`default_nettype none
module pqa_alu_monitor
    import pqa_pkg::*;
(
    // clock and reset
    input wire logic              core_clk,
    input wire logic              resetn,
    // instruction
    input wire logic              issue,
    input wire pqa_op_t           opcode,
    input wire pqa_src_t          srcA,
    input wire pqa_src_t          srcB,
    input wire logic [ADDR_W-1:0] addrA,
    input wire logic [ADDR_W-1:0] addrB,
    input wire logic [LONG_W-1:0] immVal,
    input wire logic [SCALE_W-1:0] scaleA,
    input wire logic [SCALE_W-1:0] scaleB,
    input wire logic [SCALE_W-1:0] scaleR,
    input wire logic [ADDR_W-1:0] dstBase,
    // storage
    input wire logic              rdWork_r,
    input wire logic [ADDR_W-1:0] rdAddr_r,
    input wire logic [WORD_W-1:0] rdData,
    input wire logic              wrEn_r,
    input wire logic [ADDR_W-1:0] wrAddr_r,
    input wire logic [WORD_W-1:0] wrData_r,
    // status
    input wire logic              busy_r,
    input wire logic              done_r,
    input wire logic              fault_r,
    input wire logic              faultClr
);
    logic              takeIt;
    logic [2:0]        nWr;
    pqa_op_t           opQ;
    logic [ADDR_W-1:0] dstQ;
    assign takeIt = issue && !busy_r;
    // words written since the last taken issue
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            nWr <= 3'h0;
            opQ <= OP_LONG_DIVIDE;
            dstQ <= 8'h00;
        end else if (takeIt) begin
            nWr <= 3'h0;
            opQ <= opcode;
            dstQ <= dstBase;
        end else if (wrEn_r) begin
            nWr <= nWr + 3'h1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    done_pulse_a: assert property (done_r |=> !done_r) else $error("done wider than one cycle");
    take_busy_a: assert property (takeIt |=> busy_r) else $error("busy not raised");
    issue_done_a: assert property (takeIt |-> ##[2:150] done_r) else $error("no done");
    read_pair_a: assert property (takeIt && opcode == OP_LONG_DIVIDE && srcA == SRC_WORK |=> rdWork_r
        && rdAddr_r == $past(addrA) ##1 rdAddr_r == $past(addrA, 2) + OFS_HI) else $error("operand pair read order");
    long_burst_a: assert property ($rose(wrEn_r) && opQ == OP_LONG_DIVIDE |-> wrAddr_r == dstQ
        ##1 wrEn_r && wrAddr_r == dstQ + OFS_HI ##1 wrEn_r && wrAddr_r == dstQ + OFS_REMLO
        ##1 wrEn_r && wrAddr_r == dstQ + OFS_REMHI) else $error("long divide write burst");
    words_count_a: assert property (done_r && !fault_r |=>
        fault_r || nWr == (opQ == OP_LONG_DIVIDE ? 3'h4 : 3'h2)) else $error("word count at done");
    zero_nowrite_a: assert property ($rose(fault_r) |-> nWr == 3'h0) else $error("write on fault");
    fault_hold_a: assert property (fault_r && !faultClr |=> fault_r) else $error("fault dropped");
    fault_clear_a: assert property (faultClr && !busy_r |=> !fault_r) else $error("fault not cleared");
    cover property (done_r && opQ == OP_LONG_DIVIDE);
    cover property ($rose(fault_r));
    cover property (done_r && opQ == OP_SCALED_MULTIPLY);
endmodule
bind pqa_alu pqa_alu_monitor pqa_alu_monitor_i (.core_clk(core_clk), .resetn(resetn), .issue(issue),
    .opcode(opcode), .srcA(srcA), .srcB(srcB), .addrA(addrA), .addrB(addrB), .immVal(immVal),
    .scaleA(scaleA), .scaleB(scaleB), .scaleR(scaleR), .dstBase(dstBase), .rdWork_r(rdWork_r),
    .rdAddr_r(rdAddr_r), .rdData(rdData), .wrEn_r(wrEn_r), .wrAddr_r(wrAddr_r), .wrData_r(wrData_r),
    .busy_r(busy_r), .done_r(done_r), .fault_r(fault_r), .faultClr(faultClr));
`default_nettype wire

// file: tb/pqa_alu_tb.sv
// self-checking bench for the divide and scaling datapath
`timescale 1ns/10ps
`default_nettype none
module pqa_alu_tb;
    import pqa_pkg::*;
    logic              core_clk, resetn, issue, faultClr, rdWork, wrEn, busy, done, fault;
    pqa_op_t           opcode;
    pqa_src_t          srcA, srcB;
    logic [ADDR_W-1:0] addrA, addrB, dstBase, rdAddr, wrAddr;
    logic [LONG_W-1:0] immVal, seed;
    logic [5:0]        scaleA, scaleB, scaleR;
    logic [15:0]       rdData, wrData;
    logic [23:0]       expQ [$];
    int                nErrors, samplesChecked;
    pqa_alu pqa_alu_i (.core_clk(core_clk), .resetn(resetn), .issue(issue), .opcode(opcode), .srcA(srcA),
        .srcB(srcB), .addrA(addrA), .addrB(addrB), .immVal(immVal), .scaleA(scaleA), .scaleB(scaleB),
        .scaleR(scaleR), .dstBase(dstBase), .rdWork_r(rdWork), .rdAddr_r(rdAddr), .rdData(rdData),
        .wrEn_r(wrEn), .wrAddr_r(wrAddr), .wrData_r(wrData), .busy_r(busy), .done_r(done), .fault_r(fault),
        .faultClr(faultClr));
    pqa_regs_model pqa_regs_model_i (.core_clk(core_clk), .rdWork(rdWork), .rdAddr(rdAddr), .rdData(rdData),
        .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic giveVerdict();
        $display("errors %0d checks %0d", nErrors, samplesChecked);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic load(input pqa_src_t s, input logic [7:0] a, input logic [31:0] v);
        if (s == SRC_WORK) begin
            pqa_regs_model_i.workMem[a] = v[15:0];
            pqa_regs_model_i.workMem[a + 8'h01] = v[31:16];
        end else if (s == SRC_PARAM) begin
            pqa_regs_model_i.parmMem[a] = v[15:0];
            pqa_regs_model_i.parmMem[a + 8'h01] = v[31:16];
        end else begin
            immVal = v;
        end
    endtask
    task automatic push2(input logic [7:0] a, input longint v);
        expQ.push_back({a, v[15:0]});
        expQ.push_back({a + 8'h01, v[31:16]});
    endtask
    task automatic runOp(input pqa_op_t op, input pqa_src_t sa, input pqa_src_t sb, input logic [31:0] a,
                         input logic [31:0] b, input logic [5:0] s1, input logic [5:0] s2, input logic [5:0] sr);
        longint x, y, q;
        int     k;
        logic   expFault;
        if (sa == SRC_IMM && sb == SRC_IMM) b = a;
        x = op == OP_SHORT_DIVIDE ? longint'(signed'(a[15:0])) : longint'(signed'(a));
        y = op == OP_SHORT_DIVIDE ? longint'(signed'(b[15:0])) : longint'(signed'(b));
        expFault = y == 0 && op inside {OP_LONG_DIVIDE, OP_SHORT_DIVIDE, OP_SCALED_DIVIDE};
        load(sa, 8'h10, a);
        load(sb, 8'h20, b);
        k = s1 + s2 - sr;
        q = x * y;
        if (!expFault) case (op)
            OP_LONG_DIVIDE: begin
                if (!expFault) begin
                    push2(8'h40, x / y);
                    push2(8'h42, x % y);
                end
            end
            OP_SHORT_DIVIDE: begin
                q = x / y;
                expQ.push_back({8'h40, q[15:0]});
                q = x % y;
                expQ.push_back({8'h41, q[15:0]});
            end
            OP_SCALED_DIVIDE: begin
                q = ((x < 0 ? -x : x) << sr) / (y < 0 ? -y : y);
                push2(8'h40, (x < 0) != (y < 0) ? -q : q);
            end
            OP_SCALED_MULTIPLY: push2(8'h40, k >= 0 ? q >>> k : q << -k);
            OP_INT_TO_FIXED: push2(8'h40, x << sr);
            default: push2(8'h40, x >>> sr);
        endcase
        opcode = op;
        srcA = sa;
        srcB = sb;
        addrA = 8'h10;
        addrB = 8'h20;
        dstBase = 8'h40;
        scaleA = s1;
        scaleB = s2;
        scaleR = sr;
        issue = 1'b1;
        @(posedge core_clk);
        #2 issue = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 300) begin
            @(posedge core_clk);
            #1 k++;
        end
        @(posedge core_clk);
        #2 samplesChecked++;
        if (k >= 300 || expQ.size() != 0 || fault !== expFault) begin
            nErrors++;
            $display("[ERR] %0t op %0d missing words or wrong fault", $time, op);
        end
        expQ.delete();
        faultClr = expFault;
        @(posedge core_clk);
        #2 faultClr = 1'b0;
        samplesChecked++;
        if (fault !== 1'b0) begin
            nErrors++;
            $display("[ERR] %0t fault not cleared", $time);
        end
    endtask
    always @(posedge core_clk) begin
        if (wrEn === 1'b1) begin
            samplesChecked++;
            if (expQ.size() == 0) begin
                nErrors++;
                $display("[ERR] %0t unexpected write", $time);
            end else if ({wrAddr, wrData} !== expQ.pop_front()) begin
                nErrors++;
                $display("[ERR] %0t write addr or data wrong", $time);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        $display("[ERR] %0t watchdog expired", $time);
        giveVerdict();
    end
    initial begin
        seed = 32'h0d8ae1bc;
        {resetn, issue, faultClr, addrA, addrB, dstBase, immVal, scaleA, scaleB, scaleR} = '0;
        opcode = OP_LONG_DIVIDE;
        srcA = SRC_WORK;
        srcB = SRC_WORK;
        nErrors = 0;
        samplesChecked = 0;
        repeat (2) @(posedge core_clk);
        #2 resetn = 1'b1;
        repeat (3) @(posedge core_clk);
        #2;
        runOp(OP_LONG_DIVIDE, SRC_WORK, SRC_WORK, 32'hfff0bdb9, 32'h00000025, 6'h00, 6'h00, 6'h00);
        for (int i = 0; i < 9; i++) begin
            runOp(OP_LONG_DIVIDE, pqa_src_t'(i / 3), pqa_src_t'(i % 3), rnd(), rnd() >> i, 6'h00, 6'h00, 6'h00);
        end
        runOp(OP_LONG_DIVIDE, SRC_WORK, SRC_PARAM, rnd(), 32'h00000000, 6'h00, 6'h00, 6'h00);
        runOp(OP_SHORT_DIVIDE, SRC_WORK, SRC_PARAM, 32'h00008003, 32'h00000007, 6'h00, 6'h00, 6'h00);
        runOp(OP_SHORT_DIVIDE, SRC_IMM, SRC_WORK, rnd(), 32'h0000fff9, 6'h00, 6'h00, 6'h00);
        runOp(OP_SCALED_DIVIDE, SRC_WORK, SRC_IMM, rnd(), 32'h00000000, 6'h00, 6'h00, 6'h07);
        runOp(OP_SCALED_DIVIDE, SRC_PARAM, SRC_WORK, rnd(), rnd() >> 8, 6'h00, 6'h00, 6'h07);
        runOp(OP_SCALED_DIVIDE, SRC_IMM, SRC_PARAM, rnd(), rnd(), 6'h00, 6'h00, 6'h07);
        runOp(OP_SCALED_MULTIPLY, SRC_WORK, SRC_PARAM, rnd(), rnd(), 6'h0a, 6'h02, 6'h0e);
        runOp(OP_SCALED_MULTIPLY, SRC_IMM, SRC_WORK, rnd(), rnd() >> 16, 6'h0a, 6'h02, 6'h0e);
        runOp(OP_INT_TO_FIXED, SRC_WORK, SRC_WORK, rnd(), rnd(), 6'h0e, 6'h0e, 6'h0e);
        runOp(OP_INT_TO_FIXED, SRC_PARAM, SRC_WORK, rnd(), rnd(), 6'h0e, 6'h0e, 6'h0e);
        runOp(OP_FIXED_TO_INT, SRC_WORK, SRC_WORK, rnd(), rnd(), 6'h0e, 6'h0e, 6'h0e);
        giveVerdict();
    end
endmodule
`default_nettype wire
